// ==== dv/mpt_mac_model.sv ====
`timescale 1ns/1ns
module mpt_mac_model (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire mpt_pkg::mpt_mode_t  cfg_mode,
    input  wire mpt_pkg::mpt_speed_t cfg_speed,
    input  wire logic                mgmt_gig_tx_clock,
    output logic                     mgmt_tx_clock_in,
    input  wire logic                mgmt_tx_clock_out,
    input  wire logic [7:0]          mgmt_txd,
    input  wire logic                mgmt_tx_valid,
    input  wire logic                mgmt_tx_fault
);
    import mpt_pkg::*;
    logic [3:0] cnt_q;
    logic [3:0] lo_nib;
    logic       clk_now, prev_s, prev_g, prev_o, hi_pend, lo_err, in_frm, gig4;
    logic [8:0] rx_q[$];
    int         gig_rises = 0, out_rises = 0, ext_cnt = 0, period = 0, last_rise = 0, cyc = 0;

    // Free-running clock; the port only samples it, so its phase is ours
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mgmt_tx_clock_in <= 1'b0;
            cnt_q            <= 4'h0;
        end
        else if (cnt_q == ((cfg_speed == MPT_SPD_10) ? 4'h9 : 4'h0))
        begin
            mgmt_tx_clock_in <= ~mgmt_tx_clock_in;
            cnt_q            <= 4'h0;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // Sampled mid-cycle, well away from the edges that move the lines
    always @(negedge mclk)
    begin
        cyc++;
        gig4 = (cfg_mode == MPT_RGMII) && (cfg_speed == MPT_SPD_1000);
        clk_now = (cfg_mode == MPT_MII) ? mgmt_tx_clock_in :
                  (cfg_mode == MPT_REVERSED_MII_MODE) ? mgmt_tx_clock_out : mgmt_gig_tx_clock;
        if (!rst_n)
        begin
            prev_s = 1'b0;
            prev_g = 1'b0;
            prev_o = 1'b0;
            hi_pend = 1'b0;
            in_frm = 1'b0;
        end
        else
        begin
            if (mgmt_gig_tx_clock && !prev_g)
                gig_rises++;
            if (mgmt_tx_clock_out && !prev_o)
                out_rises++;
            if (clk_now && !prev_s)
            begin
                if (mgmt_tx_valid && in_frm)
                    period = cyc - last_rise;
                last_rise = cyc;
                in_frm = mgmt_tx_valid;
                if (!mgmt_tx_valid)
                begin
                    hi_pend = 1'b0;
                    if (mgmt_tx_fault && (mgmt_txd == 8'h0f))
                        ext_cnt++;
                end
                else if (cfg_mode == MPT_GMII)
                    rx_q.push_back({mgmt_tx_fault, mgmt_txd});
                else if (hi_pend && !gig4)
                begin
                    rx_q.push_back({lo_err | mgmt_tx_fault, mgmt_txd[3:0], lo_nib});
                    hi_pend = 1'b0;
                end
                else
                begin
                    lo_nib = mgmt_txd[3:0];
                    lo_err = mgmt_tx_fault;
                    hi_pend = 1'b1;
                end
            end
            if (!clk_now && prev_s && hi_pend && gig4)
            begin
                rx_q.push_back({~mgmt_tx_valid, mgmt_txd[3:0], lo_nib});
                hi_pend = 1'b0;
            end
            prev_s = clk_now;
            prev_g = mgmt_gig_tx_clock;
            prev_o = mgmt_tx_clock_out;
        end
    end
endmodule : mpt_mac_model

// ==== dv/mpt_tx_port_tb_top.sv ====
`timescale 1ns/1ns
module mpt_tx_port_tb_top;
    import mpt_pkg::*;
    typedef struct {
        mpt_mode_t  mode;
        mpt_speed_t spd;
        int         n, err_at, per;
        bit         ext, gig, out, slow;
    } mpt_row_t;
    localparam int LIMIT = 20000;
    mpt_row_t rows[9] = '{
        '{MPT_GMII,  MPT_SPD_1000, 4,  2, 2,  0, 1, 0, 0},
        '{MPT_RGMII, MPT_SPD_1000, 4,  1, 2,  0, 1, 0, 0},
        '{MPT_RGMII, MPT_SPD_100,  3, -1, 2,  0, 1, 0, 0},
        '{MPT_RGMII, MPT_SPD_10,   2, -1, 20, 0, 1, 0, 0},
        '{MPT_MII,   MPT_SPD_100,  3,  0, 0,  0, 0, 0, 0},
        '{MPT_MII,   MPT_SPD_10,   2, -1, 0,  0, 0, 0, 0},
        '{MPT_REVERSED_MII_MODE, MPT_SPD_100,  3, -1, 2,  0, 0, 1, 0},
        '{MPT_REVERSED_MII_MODE, MPT_SPD_10,   4,  3, 20, 0, 0, 1, 1},
        '{MPT_GMII,  MPT_SPD_1000, 2, -1, 2,  1, 1, 0, 0}
    };
    logic       mclk, rst_n, src_valid, src_ready, src_last, src_err, src_ext, oe_seen;
    logic       gig_clk, clk_in, clk_out, clk_oe_n, tx_valid, tx_fault;
    logic [7:0] src_data, txd;
    mpt_mode_t  cfg_mode;
    mpt_speed_t cfg_speed;
    int         failures = 0, total_checks = 0, refusals = 0, cycles = 0;

    mpt_tx_port mpt_tx_port_inst (.mclk(mclk), .rst_n(rst_n), .cfg_mode(cfg_mode), .cfg_speed(cfg_speed),
        .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data), .src_last(src_last),
        .src_err(src_err), .src_ext(src_ext), .mgmt_gig_tx_clock(gig_clk), .mgmt_tx_clock_in(clk_in),
        .mgmt_tx_clock_out(clk_out), .mgmt_tx_clock_oe_n(clk_oe_n), .mgmt_txd(txd),
        .mgmt_tx_valid(tx_valid), .mgmt_tx_fault(tx_fault));
    mpt_mac_model mpt_mac_model_inst (.mclk(mclk), .rst_n(rst_n), .cfg_mode(cfg_mode), .cfg_speed(cfg_speed),
        .mgmt_gig_tx_clock(gig_clk), .mgmt_tx_clock_in(clk_in), .mgmt_tx_clock_out(clk_out),
        .mgmt_txd(txd), .mgmt_tx_valid(tx_valid), .mgmt_tx_fault(tx_fault));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(negedge mclk)
        if (tx_valid === 1'b1)
            oe_seen = clk_oe_n;

    task automatic report_and_stop();
        begin
            $display("checks %0d mismatches %0d", total_checks, failures);
            if ((failures == 0) && (total_checks > 0))
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask : report_and_stop

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            failures++;
            report_and_stop();
        end
    end

    task automatic check_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
        begin
            total_checks++;
            if (got !== exp)
            begin
                failures++;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask : check_vec

    task automatic check_bit(input string what, input logic exp, input logic got);
        begin
            total_checks++;
            if (got !== exp)
            begin
                failures++;
                $display("Error %s expected %b seen %b", what, exp, got);
            end
        end
    endtask : check_bit

    function automatic logic [7:0] pat(input int r, input int k);
        pat = 8'h96 ^ {r[3:0], k[3:0]};
    endfunction : pat

    // Called at a falling edge; word held until the rising edge that sees ready
    task automatic put_word(input logic [7:0] d, input logic l, input logic e, input logic x);
        begin
            src_valid = 1'b1;
            src_data = d;
            src_last = l;
            src_err = e;
            src_ext = x;
            while (src_ready !== 1'b1)
            begin
                refusals++;
                @(negedge mclk);
            end
            @(negedge mclk);
        end
    endtask : put_word

    task automatic chk_reset_outs();
        begin
            check_bit("valid in reset", 1'b0, tx_valid);
            check_bit("fault in reset", 1'b0, tx_fault);
            check_bit("clock enable in reset", 1'b1, clk_oe_n);
            check_bit("ready in reset", 1'b0, src_ready);
        end
    endtask : chk_reset_outs

    task automatic run_row(input int r);
        mpt_row_t w;
        int       g0, o0, e0, f0, k;
        begin
            w = rows[r];
            cfg_mode = w.mode;
            cfg_speed = w.spd;
            repeat (60) @(negedge mclk);
            g0 = mpt_mac_model_inst.gig_rises;
            o0 = mpt_mac_model_inst.out_rises;
            e0 = mpt_mac_model_inst.ext_cnt;
            f0 = refusals;
            oe_seen = 1'bx;
            for (k = 0; k < w.n; k++)
                put_word(pat(r, k), k == w.n - 1, k == w.err_at, 1'b0);
            if (w.ext)
                put_word(8'h00, 1'b1, 1'b0, 1'b1);
            src_valid = 1'b0;
            k = 0;
            while ((k < 600) && !((mpt_mac_model_inst.rx_q.size() >= w.n) && (tx_valid === 1'b0)))
            begin
                @(negedge mclk);
                k++;
            end
            repeat (30) @(negedge mclk);
            check_vec("frame length", 16'(w.n), 16'(mpt_mac_model_inst.rx_q.size()));
            for (k = 0; k < w.n; k++)
                check_vec("byte", {7'h00, k == w.err_at, pat(r, k)}, {7'h00, mpt_mac_model_inst.rx_q.pop_front()});
            check_bit("clock pin enable", !w.out, oe_seen);
            check_bit("gig clock active", w.gig, mpt_mac_model_inst.gig_rises != g0);
            check_bit("reverse clock active", w.out, mpt_mac_model_inst.out_rises != o0);
            if (w.per != 0)
                check_vec("clock period", 16'(w.per), 16'(mpt_mac_model_inst.period));
            check_vec("ext symbols", 16'(w.ext), 16'(mpt_mac_model_inst.ext_cnt - e0));
            if (w.slow)
                check_bit("buffer refused", 1'b1, refusals != f0);
            $display("test %0d done", r);
        end
    endtask : run_row

    // Source runs dry mid-frame: the gap must go out flagged, then data resumes
    task automatic gap_test();
        int n, k;
        begin
            put_word(8'h5a, 1'b0, 1'b0, 1'b0);
            src_valid = 1'b0;
            repeat (8) @(negedge mclk);
            put_word(8'hc3, 1'b1, 1'b0, 1'b0);
            src_valid = 1'b0;
            repeat (40) @(negedge mclk);
            n = mpt_mac_model_inst.rx_q.size();
            check_bit("gap filled", 1'b1, n > 2);
            for (k = 0; k < n; k++)
                check_vec("gap word", (k == 0) ? 16'h005a : (k == n - 1) ? 16'h00c3 : 16'h0100, {7'h00, mpt_mac_model_inst.rx_q.pop_front()});
            $display("test gap done");
        end
    endtask : gap_test

    initial
    begin
        rst_n = 1'b0;
        cfg_mode = MPT_GMII;
        cfg_speed = MPT_SPD_1000;
        src_valid = 1'b0;
        src_data = 8'h00;
        src_last = 1'b0;
        src_err = 1'b0;
        src_ext = 1'b0;
        repeat (4) @(negedge mclk);
        chk_reset_outs();
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        check_bit("ready after reset", 1'b1, src_ready);
        for (int r = 0; r < 9; r++)
            run_row(r);
        gap_test();
        cfg_mode = MPT_REVERSED_MII_MODE;
        cfg_speed = MPT_SPD_10;
        repeat (60) @(negedge mclk);
        put_word(8'h11, 1'b0, 1'b0, 1'b0);
        put_word(8'h22, 1'b0, 1'b0, 1'b0);
        src_valid = 1'b0;
        repeat (45) @(negedge mclk);
        check_bit("frame running", 1'b1, tx_valid);
        rst_n = 1'b0;
        #2;
        chk_reset_outs();
        repeat (8) @(negedge mclk);
        mpt_mac_model_inst.rx_q.delete();
        rst_n = 1'b1;
        $display("test reset done");
        run_row(0);
        report_and_stop();
    end
endmodule : mpt_tx_port_tb_top

// ==== verilog/mpt_defines.svh ====
`ifndef MPT_DEFINES_SVH
`define MPT_DEFINES_SVH

// Timing: figures in ns, counts in mclk cycles
`define MPT_MCLK_PERIOD_NS    20
`define MPT_TCLK_1000_NS      8
`define MPT_TCLK_100_NS       40
`define MPT_TCLK_10_NS        400
// Half period rounds down, never below one cycle
`define MPT_HALF_CYC(ns)      ((((ns) / 2) / `MPT_MCLK_PERIOD_NS) < 1 ? 1 : (((ns) / 2) / `MPT_MCLK_PERIOD_NS))
`define MPT_HALF_1000         `MPT_HALF_CYC(`MPT_TCLK_1000_NS)
`define MPT_HALF_100          `MPT_HALF_CYC(`MPT_TCLK_100_NS)
`define MPT_HALF_10           `MPT_HALF_CYC(`MPT_TCLK_10_NS)

// Buffer entry layout
`define MPT_BYTE_W            8
`define MPT_ENT_W             11
`define MPT_ENT_LAST          8
`define MPT_ENT_ERR           9
`define MPT_ENT_EXT           10
`define MPT_BUF_DEPTH         2

// Codes and reset values
`define MPT_EXT_CODE          8'h0f
`define MPT_TXD_RST           8'h00
`define MPT_NIB_ZERO          4'h0

`endif

// ==== verilog/mpt_edge_gen.sv ====
`timescale 1ns/1ns
module mpt_edge_gen #(
    parameter int CW = 8
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          run,
    input  wire logic [CW-1:0] half_cnt,
    output logic               rise_stb,
    output logic               fall_stb
);
    logic [CW-1:0] cnt_q;
    logic          phase_q;
    logic          at_end;

    assign at_end   = run && ((cnt_q + CW'(1)) >= half_cnt);
    assign rise_stb = at_end && !phase_q;
    assign fall_stb = at_end && phase_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q   <= '0;
            phase_q <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q   <= '0;
            phase_q <= 1'b0;
        end
        else if (at_end)
        begin
            cnt_q   <= '0;
            phase_q <= !phase_q;
        end
        else
        begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    chk_edge_alternate: assert property (@(posedge mclk) disable iff (!rst_n)
        (rise_stb || fall_stb) && (half_cnt > CW'(1)) ##1 $stable(half_cnt) |-> !rise_stb && !fall_stb)
        else $error("clock strobes closer than half period");

endmodule : mpt_edge_gen

// ==== verilog/mpt_pkg.sv ====
package mpt_pkg;

    typedef enum logic [1:0] {
        MPT_GMII  = 2'b00,
        MPT_RGMII = 2'b01,
        MPT_MII   = 2'b10,
        MPT_REVERSED_MII_MODE = 2'b11
    } mpt_mode_t;

    typedef enum logic [1:0] {
        MPT_SPD_10   = 2'b00,
        MPT_SPD_100  = 2'b01,
        MPT_SPD_1000 = 2'b10
    } mpt_speed_t;

endpackage : mpt_pkg

// ==== verilog/mpt_skid_buf.sv ====
`timescale 1ns/1ns
module mpt_skid_buf #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             ready_q;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1))
        begin
            return '0;
        end
        return p + AW'(1);
    endfunction : ptr_inc

    assign push      = in_valid && ready_q;
    assign pop       = out_valid && out_ready;
    assign in_ready  = ready_q;
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];

    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
        begin
            count_d = count_q + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            count_d = count_q - (AW+1)'(1);
        end
    end

    // Ready is registered so the source never sees a combinational path
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q  <= '0;
            ready_q  <= 1'b0;
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            count_q <= count_d;
            ready_q <= (count_d != (AW+1)'(DEPTH));
            if (push)
            begin
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if (pop)
            begin
                rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    chk_buf_no_overflow: assert property (@(posedge mclk) disable iff (!rst_n) count_q <= (AW+1)'(DEPTH))
        else $error("buffer count above depth");

endmodule : mpt_skid_buf

// ==== verilog/mpt_tx_port.sv ====
`timescale 1ns/1ns
`include "mpt_defines.svh"
module mpt_tx_port #(
    parameter int CW        = 8,
    parameter int BUF_DEPTH = `MPT_BUF_DEPTH
) (
    input  wire logic                           mclk,
    input  wire logic                           rst_n,
    input  wire mpt_pkg::mpt_mode_t             cfg_mode,
    input  wire mpt_pkg::mpt_speed_t            cfg_speed,
    input  wire logic                           src_valid,
    output logic                                src_ready,
    input  wire logic [`MPT_BYTE_W-1:0]         src_data,
    input  wire logic                           src_last,
    input  wire logic                           src_err,
    input  wire logic                           src_ext,
    output logic                                mgmt_gig_tx_clock,
    input  wire logic                           mgmt_tx_clock_in,
    output logic                                mgmt_tx_clock_out,
    output logic                                mgmt_tx_clock_oe_n,
    output logic      [`MPT_BYTE_W-1:0]         mgmt_txd,
    output logic                                mgmt_tx_valid,
    output logic                                mgmt_tx_fault
);
    import mpt_pkg::*;

    mpt_mode_t             mode_q;
    mpt_speed_t            speed_q;
    logic                  tclk_prev_q;
    logic                  gig_clk_q;
    logic                  tclk_out_q;
    logic                  tclk_oe_n_q;
    logic [`MPT_BYTE_W-1:0] txd_q;
    logic                  valid_q;
    logic                  fault_q;
    logic [`MPT_BYTE_W-1:0] hold_q;
    logic                  hold_vld_q;
    logic                  hold_err_q;
    logic                  ctl_fall_q;
    logic                  nib_hi_q;
    logic                  in_frame_q;

    logic                  buf_valid;
    logic                  buf_pop;
    logic [`MPT_ENT_W-1:0] buf_data;
    logic                  gen_rise;
    logic                  gen_fall;
    logic                  gen_run;
    logic                  mii_rise;
    logic                  edge_rise;
    logic                  edge_fall;
    logic                  nibble;
    logic                  fetch;
    logic                  w_vld;
    logic                  w_err;
    logic [`MPT_BYTE_W-1:0] w_byte;

    function automatic logic is_nibble(input mpt_mode_t m, input mpt_speed_t s);
        return (m == MPT_MII) || (m == MPT_REVERSED_MII_MODE) || ((m == MPT_RGMII) && (s != MPT_SPD_1000));
    endfunction : is_nibble

    function automatic mpt_speed_t eff_speed(input mpt_mode_t m, input mpt_speed_t s);
        if (m == MPT_GMII)
        begin
            return MPT_SPD_1000;
        end
        if ((m != MPT_RGMII) && (s == MPT_SPD_1000))
        begin
            return MPT_SPD_100;
        end
        return s;
    endfunction : eff_speed

    function automatic logic [CW-1:0] half_of(input mpt_speed_t s);
        case (s)
            MPT_SPD_1000: return CW'(`MPT_HALF_1000);
            MPT_SPD_100:  return CW'(`MPT_HALF_100);
            default:      return CW'(`MPT_HALF_10);
        endcase
    endfunction : half_of

    mpt_skid_buf #(
        .WIDTH (`MPT_ENT_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (src_valid),
        .in_ready  (src_ready),
        .in_data   ({src_ext, src_err, src_last, src_data}),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_data)
    );

    // Generated clock only where this end owns the clock
    assign gen_run = (mode_q != MPT_MII);
    mpt_edge_gen #(
        .CW (CW)
    ) u_edge (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .run      (gen_run),
        .half_cnt (half_of(speed_q)),
        .rise_stb (gen_rise),
        .fall_stb (gen_fall)
    );

    // MAC clock input is synchronous to mclk, so a plain delay finds its rise
    assign mii_rise  = mgmt_tx_clock_in && !tclk_prev_q;
    assign edge_rise = gen_run ? gen_rise : mii_rise;
    assign edge_fall = gen_run && gen_fall;
    assign nibble    = is_nibble(mode_q, speed_q);
    assign fetch     = !nib_hi_q;
    assign buf_pop   = edge_rise && fetch && buf_valid;

    // Carrier extension has no nibble-mode form and is sent as idle there
    always_comb
    begin
        w_vld  = 1'b0;
        w_err  = 1'b0;
        w_byte = `MPT_TXD_RST;
        if (buf_valid)
        begin
            if (buf_data[`MPT_ENT_EXT])
            begin
                w_err  = !nibble;
                w_byte = nibble ? `MPT_TXD_RST : `MPT_EXT_CODE;
            end
            else
            begin
                w_vld  = 1'b1;
                w_err  = buf_data[`MPT_ENT_ERR];
                w_byte = buf_data[`MPT_BYTE_W-1:0];
            end
        end
        else if (in_frame_q)
        begin
            // Underrun mid-frame: poison the frame rather than cut it short
            w_vld = 1'b1;
            w_err = 1'b1;
        end
    end

    // Mode and speed change only between frames
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q  <= MPT_GMII;
            speed_q <= MPT_SPD_1000;
        end
        else if (!in_frame_q && !nib_hi_q)
        begin
            mode_q  <= cfg_mode;
            speed_q <= eff_speed(cfg_mode, cfg_speed);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tclk_prev_q <= 1'b0;
        end
        else
        begin
            tclk_prev_q <= mgmt_tx_clock_in;
        end
    end

    // Clock pins; driven levels toggle in the same edge as the data they time
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gig_clk_q   <= 1'b0;
            tclk_out_q  <= 1'b0;
            tclk_oe_n_q <= 1'b1;
        end
        else
        begin
            tclk_oe_n_q <= (mode_q != MPT_REVERSED_MII_MODE);
            if ((mode_q == MPT_GMII) || (mode_q == MPT_RGMII))
            begin
                if (gen_rise)
                begin
                    gig_clk_q <= 1'b1;
                end
                else if (gen_fall)
                begin
                    gig_clk_q <= 1'b0;
                end
            end
            else
            begin
                gig_clk_q <= 1'b0;
            end
            if (mode_q == MPT_REVERSED_MII_MODE)
            begin
                if (gen_rise)
                begin
                    tclk_out_q <= 1'b1;
                end
                else if (gen_fall)
                begin
                    tclk_out_q <= 1'b0;
                end
            end
            else
            begin
                tclk_out_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_frame_q <= 1'b0;
        end
        else if (buf_pop && !buf_data[`MPT_ENT_EXT])
        begin
            in_frame_q <= !buf_data[`MPT_ENT_LAST];
        end
    end

    // Data and control launch
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txd_q      <= `MPT_TXD_RST;
            valid_q    <= 1'b0;
            fault_q    <= 1'b0;
            hold_q     <= `MPT_TXD_RST;
            hold_vld_q <= 1'b0;
            hold_err_q <= 1'b0;
            ctl_fall_q <= 1'b0;
            nib_hi_q   <= 1'b0;
        end
        else if (edge_rise && fetch)
        begin
            hold_q     <= w_byte;
            hold_vld_q <= w_vld;
            hold_err_q <= w_err;
            ctl_fall_q <= w_vld ^ w_err;
            nib_hi_q   <= nibble;
            valid_q    <= w_vld;
            case (mode_q)
                MPT_GMII:
                begin
                    txd_q   <= w_byte;
                    fault_q <= w_err;
                end
                MPT_RGMII:
                begin
                    txd_q   <= {`MPT_NIB_ZERO, w_byte[3:0]};
                    fault_q <= 1'b0;
                end
                default:
                begin
                    txd_q   <= {`MPT_NIB_ZERO, w_byte[3:0]};
                    fault_q <= w_err;
                end
            endcase
        end
        else if (edge_rise)
        begin
            txd_q      <= {`MPT_NIB_ZERO, hold_q[7:4]};
            valid_q    <= hold_vld_q;
            fault_q    <= (mode_q != MPT_RGMII) && hold_err_q;
            ctl_fall_q <= hold_vld_q ^ hold_err_q;
            nib_hi_q   <= 1'b0;
        end
        else if (edge_fall && (mode_q == MPT_RGMII))
        begin
            valid_q <= ctl_fall_q;
            if (!nibble)
            begin
                txd_q <= {`MPT_NIB_ZERO, hold_q[7:4]};
            end
        end
    end

    assign mgmt_gig_tx_clock  = gig_clk_q;
    assign mgmt_tx_clock_out  = tclk_out_q;
    assign mgmt_tx_clock_oe_n = tclk_oe_n_q;
    assign mgmt_txd           = txd_q;
    assign mgmt_tx_valid      = valid_q;
    assign mgmt_tx_fault      = fault_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_gmii_fetch;
        (mode_q == MPT_GMII) && edge_rise && buf_valid && !buf_data[`MPT_ENT_EXT];
    endsequence

    sequence s_rgmii_gig_rise;
        (mode_q == MPT_RGMII) && !nibble && edge_rise && fetch;
    endsequence

    chk_reset_quiet: assert property ($rose(rst_n) |-> !mgmt_tx_valid && !mgmt_tx_fault)
        else $error("valid or fault high out of reset");

    chk_gmii_byte_out: assert property (s_gmii_fetch |=> mgmt_txd == $past(buf_data[7:0]) && mgmt_tx_valid)
        else $error("GMII byte not presented on rise");

    chk_gmii_clk_rise: assert property (s_gmii_fetch |=> mgmt_gig_tx_clock)
        else $error("GMII clock not high with new byte");

    chk_rgmii_hi_nibble: assert property (s_rgmii_gig_rise ##1 edge_fall |=> mgmt_txd[3:0] == $past(hold_q[7:4]))
        else $error("RGMII high nibble missing on fall");

    chk_rgmii_ctl_fall: assert property ((mode_q == MPT_RGMII) && edge_fall |=> mgmt_tx_valid == $past(ctl_fall_q))
        else $error("RGMII control wrong on fall");

    chk_rgmii_clk_rate: assert property ((mode_q == MPT_RGMII) && (speed_q != MPT_SPD_10) && $stable(mode_q)
        && $stable(speed_q) && $rose(mgmt_gig_tx_clock) |=> !mgmt_gig_tx_clock)
        else $error("RGMII clock half period not one cycle");

    chk_rgmii_slow_hold: assert property ((mode_q == MPT_RGMII) && nibble && edge_fall |=> $stable(mgmt_txd))
        else $error("RGMII slow data changed on fall");

    chk_mii_in_clock: assert property ((mode_q == MPT_MII) && $past(mode_q == MPT_MII) |-> mgmt_tx_clock_oe_n
        && !mgmt_tx_clock_out)
        else $error("MII mode drives the clock pin");

    chk_mii_launch_edge: assert property ((mode_q == MPT_MII) && $changed(mgmt_txd) |-> $past(mii_rise))
        else $error("MII data moved without MAC clock rise");

    chk_reversed_mii_mode_drive: assert property ((mode_q == MPT_REVERSED_MII_MODE) && $past(mode_q == MPT_REVERSED_MII_MODE) |-> !mgmt_tx_clock_oe_n)
        else $error("reversed MII not driving clock");

    chk_fault_meaning: assert property (mgmt_tx_fault && !mgmt_tx_valid |-> mgmt_txd == `MPT_EXT_CODE)
        else $error("fault without valid is not extension");

endmodule : mpt_tx_port
